// ### hdl/rcs_consts.svh
// register offsets, field positions and reset values of the regulator control slave
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
`define RCS_OFS_ID 3'h0
`define RCS_OFS_CFG0 3'h1
`define RCS_OFS_CFG1 3'h2
`define RCS_OFS_CFG2 3'h3
`define RCS_OFS_CFG3 3'h4
`define RCS_OFS_STAT 3'h5
`define RCS_OFS_INT 3'h6
`define RCS_OFS_MSK 3'h7
`define RCS_LAST_OFS 8'h07
`define RCS_EN_BIT 7
`define RCS_OUTPUT_VOLTAGE_CODE_MSB 5
`define RCS_FORCE_BIT 5
`define RCS_INTEG_BIT 2
`define RCS_SCALE_BIT 0
`define RCS_INUV_BIT 0
`define RCS_OUTOK_BIT 1
`define RCS_CFG0_RST 8'h50
`define RCS_CFG1_RST 8'hC0
`define RCS_CFG2_RST 8'h00
`define RCS_CFG3_RST 8'h04
`define RCS_MSK_RST 8'h00
`define RCS_BYTE_BITS 4'h8
`endif

// ### hdl/rcs_pkg.sv
// types and helpers of the regulator control slave
`include "rcs_consts.svh"
package rcs_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } rcs_wr_t;
  typedef struct packed {
    logic tj_hi;
    logic tj_warm;
    logic out_uv;
    logic in_uv;
  } rcs_mon_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_DACK = 3'h3,
    ST_REG = 3'h2,
    ST_RACK = 3'h6,
    ST_WDAT = 3'h7,
    ST_TX = 3'h5,
    ST_TACK = 3'h4
  } rcs_state_t;
  function automatic logic rcs_reg_ok(input logic [7:0] a);
    return a <= `RCS_LAST_OFS;
  endfunction : rcs_reg_ok
  function automatic logic [2:0] rcs_next_ptr(input logic [2:0] p);
    return (p == `RCS_OFS_ID) ? p : 3'(p + 3'h1);
  endfunction : rcs_next_ptr
endpackage : rcs_pkg

// ### hdl/rcs_sync.sv
// two flip-flop level synchroniser
module rcs_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] m_q;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      m_q <= '0;
      q_o <= '0;
    end
    else
    begin
      m_q <= d_i;
      q_o <= m_q;
    end
  end
endmodule : rcs_sync

// ### hdl/rcs_top.sv
// regulator control logic with serial register slave
//
// Function
// - integrator_enable 0 gives proportional-only loop, 1 enables the integrator
// - switch_scaling_select 1 picks light-load configuration, 0 favours high load
// - forced input supply: output shuts down when input drops below threshold
// - supply from output: keep running, stop only on output low, thermal shutdown or disable
// - input below falling threshold sets input_low_flag and raises interrupt
// - junction above rising threshold enters thermal shutdown, regulation stops
// - below falling thermal threshold regulation restarts without toggling enable
// - new output_voltage_code at 0x02[5:0] applies any time without restart
// - enable reset value is factory set; host writes enable to wake
// - slave works from zero up to 680kHz serial clock; master keeps below
// - answer only one factory-chosen 7-bit address, then read/write bit
// - acknowledge register address only when valid, otherwise not-acknowledge
// - address increments after each byte except when register 0x00 accessed
// - serial clock line is never driven low, no stretching
// - general call address of all zeros is never acknowledged
`include "rcs_consts.svh"
module rcs_top
  import rcs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h68,
  parameter logic EN_RESET = 1'b1,
  parameter logic [5:0] OUTPUT_VOLTAGE_CODE_RESET = 6'h00,
  parameter logic [7:0] CHIP_ID = 8'hA5 // arbitrary value
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic LINK_CLK_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic IN_UV_I,
  input wire logic OUT_UV_I,
  input wire logic TJ_HI_I,
  input wire logic TJ_WARM_I,
  output logic REG_RUN_O,
  output logic [5:0] OUTPUT_VOLTAGE_CODE_O,
  output logic [7:0] IPEAK_O,
  output logic INTEG_EN_O,
  output logic FET_SCALE_O,
  output logic SUP_FROM_IN_O,
  output logic THERM_SD_O,
  output logic IRQ_N_O
);

  // ****************************************
  // link side: pin sampling and conditions
  // ****************************************
  logic [1:0] pin_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_r;
  logic scl_f;
  logic st;
  logic sp;
  logic [3:0] stat_s;

  rcs_sync #(.W(2)) u_pin_sync (
    .clk_i(LINK_CLK_I),
    .rstn_i(RSTN_I),
    .d_i({SCL_I, SDA_I}),
    .q_o(pin_s)
  );

  always_ff @(posedge LINK_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
    end
    else
    begin
      scl_p_q <= pin_s[1];
      sda_p_q <= pin_s[0];
    end
  end

  assign scl_r = pin_s[1] & ~scl_p_q;
  assign scl_f = ~pin_s[1] & scl_p_q;
  assign st = pin_s[1] & scl_p_q & sda_p_q & ~pin_s[0];
  assign sp = pin_s[1] & scl_p_q & ~sda_p_q & pin_s[0];

  // ****************************************
  // link side: byte engine
  // ****************************************
  rcs_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] tx_q;
  logic [2:0] ptr_q;
  logic oe_q;
  logic rnw_q;
  logic mack_q;
  logic byte_end;
  logic [7:0] sh_q [1:4];
  logic [7:0] shm_q;
  rcs_wr_t wr_q;
  logic tgl_q;
  logic [7:0] rd_cur;
  logic [7:0] rd_nxt;

  assign byte_end = scl_f && (cnt_q == `RCS_BYTE_BITS);

  function automatic logic [7:0] rd_byte(input logic [2:0] p);
    logic [7:0] v;
    v = 8'h00;
    case (p)
      `RCS_OFS_ID: v = CHIP_ID;
      `RCS_OFS_STAT: v = {6'h00, stat_s[1:0]};
      `RCS_OFS_INT: v = {6'h00, stat_s[3:2]};
      `RCS_OFS_MSK: v = shm_q;
      default: v = sh_q[p];
    endcase
    return v;
  endfunction : rd_byte

  // current and following read byte
  always_comb
  begin
    rd_cur = rd_byte(ptr_q);
    rd_nxt = rd_byte(rcs_next_ptr(ptr_q));
  end

  always_ff @(posedge LINK_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 3'h0;
      oe_q <= 1'b0;
      rnw_q <= 1'b0;
      mack_q <= 1'b0;
    end
    else if (sp)
    begin
      st_q <= ST_IDLE;
      oe_q <= 1'b0;
    end
    else if (st)
    begin
      st_q <= ST_DEV;
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_DEV, ST_REG, ST_WDAT:
        begin
          if (scl_r)
          begin
            sr_q <= {sr_q[6:0], pin_s[0]};
            cnt_q <= 4'(cnt_q + 4'h1);
          end
          else if (byte_end)
          begin
            cnt_q <= 4'h0;
            if (st_q == ST_DEV)
            begin
              if (sr_q[7:1] == SLAVE_ADDR && sr_q[7:1] != 7'h00)
              begin
                oe_q <= 1'b1;
                rnw_q <= sr_q[0];
                st_q <= ST_DACK;
              end
              else
                st_q <= ST_IDLE;
            end
            else if (st_q == ST_REG)
            begin
              if (rcs_reg_ok(sr_q))
              begin
                oe_q <= 1'b1;
                ptr_q <= sr_q[2:0];
                st_q <= ST_RACK;
              end
              else
                st_q <= ST_IDLE;
            end
            else
            begin
              oe_q <= 1'b1;
              ptr_q <= rcs_next_ptr(ptr_q);
              st_q <= ST_RACK;
            end
          end
        end
        ST_DACK:
        begin
          if (scl_f && rnw_q)
          begin
            oe_q <= ~rd_cur[7];
            tx_q <= {rd_cur[6:0], 1'b0};
            st_q <= ST_TX;
          end
          else if (scl_f)
          begin
            oe_q <= 1'b0;
            st_q <= ST_REG;
          end
        end
        ST_RACK:
        begin
          if (scl_f)
          begin
            oe_q <= 1'b0;
            st_q <= ST_WDAT;
          end
        end
        ST_TX:
        begin
          if (scl_r)
            cnt_q <= 4'(cnt_q + 4'h1);
          else if (byte_end)
          begin
            oe_q <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= ST_TACK;
          end
          else if (scl_f)
          begin
            oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        ST_TACK:
        begin
          if (scl_r)
            mack_q <= ~pin_s[0];
          else if (scl_f && mack_q)
          begin
            ptr_q <= rcs_next_ptr(ptr_q);
            oe_q <= ~rd_nxt[7];
            tx_q <= {rd_nxt[6:0], 1'b0};
            st_q <= ST_TX;
          end
          else if (scl_f)
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // open drain data line only; clock line has no driver at all
  assign SDA_O = 1'b0;
  assign SDA_OE_O = oe_q;

  // ****************************************
  // link side: shadow copy and write hand-off
  // ****************************************
  always_ff @(posedge LINK_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sh_q[1] <= {EN_RESET, 7'(`RCS_CFG0_RST)};
      sh_q[2] <= `RCS_CFG1_RST | {2'h0, OUTPUT_VOLTAGE_CODE_RESET};
      sh_q[3] <= `RCS_CFG2_RST;
      sh_q[4] <= `RCS_CFG3_RST;
      shm_q <= `RCS_MSK_RST;
      wr_q <= '0;
      tgl_q <= 1'b0;
    end
    else if (st_q == ST_WDAT && byte_end && !sp && !st)
    begin
      if (ptr_q >= `RCS_OFS_CFG0 && ptr_q <= `RCS_OFS_CFG3)
        sh_q[ptr_q] <= sr_q;
      if (ptr_q == `RCS_OFS_MSK)
        shm_q <= sr_q;
      if (ptr_q != `RCS_OFS_ID)
      begin
        wr_q <= '{addr: ptr_q, data: sr_q};
        tgl_q <= ~tgl_q;
      end
    end
  end

  // ****************************************
  // core side: crossing in, and status crossing back to the link side
  // ****************************************
  rcs_mon_t mon_s;
  logic tgl_s;
  logic tgl_p_q;
  logic wr_evt;
  logic [7:0] cfg_q [1:4];
  logic [7:0] msk_q;
  logic [1:0] int_q;
  logic [1:0] ev;
  logic in_uv_p_q;
  logic outok_p_q;
  logic tsd_q;
  logic run_q;

  rcs_sync #(.W(4)) u_mon_sync (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .d_i({TJ_HI_I, TJ_WARM_I, OUT_UV_I, IN_UV_I}),
    .q_o(mon_s)
  );

  rcs_sync #(.W(1)) u_wr_sync (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .d_i(tgl_q),
    .q_o(tgl_s)
  );

  rcs_sync #(.W(4)) u_stat_sync (
    .clk_i(LINK_CLK_I),
    .rstn_i(RSTN_I),
    .d_i({int_q, ~mon_s.out_uv, mon_s.in_uv}),
    .q_o(stat_s)
  );

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      tgl_p_q <= 1'b0;
    else
      tgl_p_q <= tgl_s;
  end

  assign wr_evt = tgl_s ^ tgl_p_q;

  // ****************************************
  // core side: configuration registers
  // ****************************************
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      cfg_q[1] <= {EN_RESET, 7'(`RCS_CFG0_RST)};
      cfg_q[2] <= `RCS_CFG1_RST | {2'h0, OUTPUT_VOLTAGE_CODE_RESET};
      cfg_q[3] <= `RCS_CFG2_RST;
      cfg_q[4] <= `RCS_CFG3_RST;
      msk_q <= `RCS_MSK_RST;
    end
    else if (wr_evt)
    begin
      if (wr_q.addr >= `RCS_OFS_CFG0 && wr_q.addr <= `RCS_OFS_CFG3)
        cfg_q[wr_q.addr] <= wr_q.data;
      if (wr_q.addr == `RCS_OFS_MSK)
        msk_q <= wr_q.data;
    end
  end

  // ****************************************
  // core side: status flags and interrupt
  // ****************************************
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      in_uv_p_q <= 1'b0;
      outok_p_q <= 1'b1;
    end
    else
    begin
      in_uv_p_q <= mon_s.in_uv;
      outok_p_q <= ~mon_s.out_uv;
    end
  end

  assign ev[`RCS_INUV_BIT] = mon_s.in_uv & ~in_uv_p_q;
  assign ev[`RCS_OUTOK_BIT] = ~mon_s.out_uv & ~outok_p_q;

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      int_q <= 2'h0;
    else if (wr_evt && wr_q.addr == `RCS_OFS_INT)
      int_q <= (int_q & ~wr_q.data[1:0]) | ev;
    else
      int_q <= int_q | ev;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      IRQ_N_O <= 1'b1;
    else
      IRQ_N_O <= ~|(int_q & ~msk_q[1:0]);
  end

  // ****************************************
  // core side: shutdown and run decision
  // ****************************************
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      tsd_q <= 1'b0;
    else if (mon_s.tj_hi)
      tsd_q <= 1'b1;
    else if (!mon_s.tj_warm)
      tsd_q <= 1'b0;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      run_q <= 1'b0;
    else
      run_q <= cfg_q[1][`RCS_EN_BIT] & ~tsd_q & ~mon_s.out_uv
        & ~(cfg_q[4][`RCS_FORCE_BIT] & mon_s.in_uv);
  end

  assign REG_RUN_O = run_q;
  assign THERM_SD_O = tsd_q;
  assign OUTPUT_VOLTAGE_CODE_O = cfg_q[2][`RCS_OUTPUT_VOLTAGE_CODE_MSB:0];
  assign IPEAK_O = cfg_q[3];
  assign INTEG_EN_O = cfg_q[4][`RCS_INTEG_BIT];
  assign FET_SCALE_O = cfg_q[4][`RCS_SCALE_BIT];
  assign SUP_FROM_IN_O = cfg_q[4][`RCS_FORCE_BIT];

  // ****************************************
  // checks
  // ****************************************
  a_gc_nack: assert property (@(posedge LINK_CLK_I) disable iff (!RSTN_I)
    st_q == ST_DEV && byte_end && sr_q == 8'h00 |=> !oe_q && st_q == ST_IDLE)
    else $error("general call acknowledged");
  a_dev_ack: assert property (@(posedge LINK_CLK_I) disable iff (!RSTN_I)
    st_q == ST_DEV && byte_end && sr_q[7:1] == SLAVE_ADDR |=> oe_q && st_q == ST_DACK)
    else $error("own address not acknowledged");
  a_reg_nack: assert property (@(posedge LINK_CLK_I) disable iff (!RSTN_I)
    st_q == ST_REG && byte_end && sr_q > `RCS_LAST_OFS |=> !oe_q)
    else $error("bad register address acknowledged");
  a_ptr_fixed: assert property (@(posedge LINK_CLK_I) disable iff (!RSTN_I)
    st_q == ST_WDAT && byte_end && ptr_q == 3'h0 |=> ptr_q == 3'h0)
    else $error("pointer moved off register zero");
  a_therm_trip: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    mon_s.tj_hi |=> tsd_q ##1 !run_q)
    else $error("no thermal shutdown");
  a_auto_restart: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    $fell(tsd_q) && cfg_q[1][7] && !mon_s.out_uv && !mon_s.in_uv |=> run_q)
    else $error("no restart after thermal shutdown");
  a_force_in: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    cfg_q[4][5] && mon_s.in_uv |=> !run_q)
    else $error("runs on low input with forced supply");
  a_low_vin: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !cfg_q[4][5] && cfg_q[1][7] && !tsd_q && !mon_s.out_uv |=> run_q)
    else $error("stopped while supplied from output");
  a_flag_set: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    $rose(mon_s.in_uv) |=> int_q[0] ##1 (msk_q[0] || !IRQ_N_O))
    else $error("input low flag or interrupt missing");
  a_output_voltage_code_apply: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wr_evt && wr_q.addr == 3'h2 |=> OUTPUT_VOLTAGE_CODE_O == $past(wr_q.data[5:0]))
    else $error("voltage code not applied");
  a_output_voltage_code_hold: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !wr_evt |=> $stable(OUTPUT_VOLTAGE_CODE_O))
    else $error("voltage code changed without write");
  a_integ_sel: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wr_evt && wr_q.addr == 3'h4 |=> INTEG_EN_O == $past(wr_q.data[2]))
    else $error("integrator select not applied");
  a_scale_sel: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wr_evt && wr_q.addr == 3'h4 |=> FET_SCALE_O == $past(wr_q.data[0]))
    else $error("scaling select not applied");
  c_write: cover property (@(posedge CLK_I) disable iff (!RSTN_I) wr_evt);
  c_read: cover property (@(posedge LINK_CLK_I) disable iff (!RSTN_I) st_q == ST_TACK);
  c_tsd: cover property (@(posedge CLK_I) disable iff (!RSTN_I) $fell(tsd_q));
  c_irq: cover property (@(posedge CLK_I) disable iff (!RSTN_I) !IRQ_N_O);
endmodule : rcs_top

// ### verification/rcs_host.sv
// host model: two-wire bus master with the data line pull-up
module rcs_host (
  input wire logic dev_pull_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // bus timing and wire level
  // ****
  // 750 ns half period, about 667 kHz
  localparam int HALF = 750;
  logic drv_low_q = 1'h0;
  initial scl_o = 1'h1;
  // released line floats high through the pull-up
  assign sda_o = !(drv_low_q || dev_pull_i);
  // ****
  // bit, byte and framing tasks
  // ****
  task automatic bit_io(input logic b, output logic r);
    #(HALF / 2) drv_low_q = !b;
    #(HALF / 2) scl_o = 1'h1;
    #(HALF / 2) r = sda_o;
    #(HALF / 2) scl_o = 1'h0;
  endtask : bit_io
  // eight bits msb first, then the acknowledge slot; a 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic n);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], q[i]);
    end
    bit_io(a, n);
  endtask : xfer
  // start or repeated start: data falls while clock high
  task automatic start;
    #(HALF / 2) drv_low_q = 1'h0;
    #(HALF / 2) scl_o = 1'h1;
    #(HALF) drv_low_q = 1'h1;
    #(HALF) scl_o = 1'h0;
  endtask : start
  task automatic stop;
    #(HALF / 2) drv_low_q = 1'h1;
    #(HALF / 2) scl_o = 1'h1;
    #(HALF) drv_low_q = 1'h0;
    #(HALF);
  endtask : stop
endmodule : rcs_host

// ### verification/rcs_top_tb.sv
// self-checking bench of the regulator control slave
`define CHK(nm, got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module rcs_top_tb;
  import rcs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // signals, clocks and instances
  // ****
  logic clk = 1'h0, link_clk = 1'h0, rst_n;
  logic sda_val;
  logic in_uv = 1'h0, out_uv = 1'h0, tj_hi = 1'h0, tj_warm = 1'h0;
  logic scl, sda, sda_oe, reg_run, integ, scale, sup_in, therm, irq_n;
  logic [5:0] output_voltage_code;
  logic [7:0] ipeak;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  initial
  begin
    forever #5 clk = !clk;
  end
  initial
  begin
    #37;
    forever #62.5 link_clk = !link_clk;
  end
  rcs_host i_host (.dev_pull_i(sda_oe), .scl_o(scl), .sda_o(sda));
  rcs_top i_dut (
    .CLK_I(clk), .RSTN_I(rst_n), .LINK_CLK_I(link_clk), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_val), .SDA_OE_O(sda_oe), .IN_UV_I(in_uv), .OUT_UV_I(out_uv),
    .TJ_HI_I(tj_hi),
    .TJ_WARM_I(tj_warm), .REG_RUN_O(reg_run), .OUTPUT_VOLTAGE_CODE_O(output_voltage_code), .IPEAK_O(ipeak),
    .INTEG_EN_O(integ), .FET_SCALE_O(scale), .SUP_FROM_IN_O(sup_in), .THERM_SD_O(therm),
    .IRQ_N_O(irq_n)
  );
  // ****
  // shared tasks
  // ****
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] ra, input logic [7:0] d [$]);
    logic [7:0] q;
    logic n;
    i_host.start();
    i_host.xfer(8'hD0, 1'h1, q, n);
    `CHK("address ack", n, 1'h0)
    i_host.xfer(ra, 1'h1, q, n);
    `CHK("register ack", n, 1'h0)
    foreach (d[i])
    begin
      i_host.xfer(d[i], 1'h1, q, n);
      `CHK("data ack", n, 1'h0)
    end
    i_host.stop();
    step(1);
  endtask : wr
  task automatic rd(input logic [7:0] ra, input logic [7:0] e [$]);
    logic [7:0] q;
    logic n;
    i_host.start();
    i_host.xfer(8'hD0, 1'h1, q, n);
    i_host.xfer(ra, 1'h1, q, n);
    i_host.start();
    i_host.xfer(8'hD1, 1'h1, q, n);
    `CHK("read address ack", n, 1'h0)
    foreach (e[i])
    begin
      i_host.xfer(8'hFF, i == e.size() - 1, q, n);
      `CHK("read data", q, e[i])
    end
    i_host.stop();
    step(1);
  endtask : rd
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    #1;
    rst_n = 1'h0;
    step(4);
    `CHK("reset outputs", {output_voltage_code, ipeak, integ, scale, sup_in, therm, irq_n, sda_oe, reg_run},
         {6'h00, 8'h00, 7'h44})
    `CHK("drive level", sda_val, 1'h0)
    step(4);
    rst_n = 1'h1;
    step(60);
    `CHK("enabled at reset", reg_run, 1'h1)
    $display("reset test done");
  endtask : t_reset
  task automatic t_config;
    wr(8'h02, '{8'h15});
    `CHK("voltage code", output_voltage_code, 6'h15)
    `CHK("still running", reg_run, 1'h1)
    wr(8'h03, '{8'hA7, 8'h25});
    `CHK("peak setting", ipeak, 8'hA7)
    `CHK("loop options", {integ, scale, sup_in}, 3'h7)
    rd(8'h02, '{8'h15, 8'hA7, 8'h25});
    rd(8'h00, '{8'hA5, 8'hA5});
    $display("config test done");
  endtask : t_config
  task automatic t_refuse;
    logic [7:0] bad [3] = '{8'hD8, 8'hDC, 8'h00};
    logic [7:0] q;
    logic n;
    foreach (bad[i])
    begin
      i_host.start();
      i_host.xfer(bad[i], 1'h1, q, n);
      `CHK("foreign address", n, 1'h1)
    end
    i_host.start();
    i_host.xfer(8'hD0, 1'h1, q, n);
    i_host.xfer(8'h08, 1'h1, q, n);
    `CHK("bad register", n, 1'h1)
    i_host.stop();
    wr(8'h00, '{8'h12, 8'h34});
    `CHK("register zero held", reg_run, 1'h1)
    $display("refuse test done");
  endtask : t_refuse
  task automatic t_supply;
    in_uv = 1'h1;
    step(6);
    `CHK("input low stop", reg_run, 1'h0)
    `CHK("input low irq", irq_n, 1'h0)
    rd(8'h05, '{8'h03});
    wr(8'h04, '{8'h05});
    `CHK("output supply run", reg_run, 1'h1)
    in_uv = 1'h0;
    wr(8'h06, '{8'h03});
    `CHK("irq cleared", irq_n, 1'h1)
    out_uv = 1'h1;
    step(6);
    `CHK("output low stop", reg_run, 1'h0)
    out_uv = 1'h0;
    step(6);
    `CHK("output back", reg_run, 1'h1)
    $display("supply test done");
  endtask : t_supply
  task automatic t_thermal;
    tj_warm = 1'h1;
    tj_hi = 1'h1;
    step(6);
    `CHK("hot shutdown", {therm, reg_run}, 2'h2)
    tj_hi = 1'h0;
    step(6);
    `CHK("hysteresis", {therm, reg_run}, 2'h2)
    tj_warm = 1'h0;
    step(6);
    `CHK("auto restart", {therm, reg_run}, 2'h1)
    $display("thermal test done");
  endtask : t_thermal
  task automatic t_enable;
    wr(8'h01, '{8'h50, 8'h2A});
    `CHK("disabled", reg_run, 1'h0)
    `CHK("code retained", output_voltage_code, 6'h2A)
    wr(8'h01, '{8'hD0});
    `CHK("woken", reg_run, 1'h1)
    $display("enable test done");
  endtask : t_enable
  initial
  begin
    t_reset();
    t_config();
    t_refuse();
    t_supply();
    t_thermal();
    t_enable();
    complete_run();
  end
endmodule : rcs_top_tb
